// >>> logic/host_pins_defines.svh
`ifndef HOST_PINS_DEFINES_SVH
`define HOST_PINS_DEFINES_SVH

// Register offsets (byte addresses, one word each)
`define REG_CTRL        8'h00
`define REG_STATE       8'h04
`define REG_SUPPLY_THR  8'h08
`define REG_RSSI_THR    8'h0C
`define REG_MEAS        8'h10
`define REG_IRQ_STAT    8'h14
`define REG_IRQ_MASK    8'h18
`define REG_EVENT       8'h1C

// Control register fields
`define CTRL_LOW_POWER  0
`define CTRL_CONNECT    1
`define CTRL_SESSION    2
`define CTRL_RADIO_ACT  3
`define CTRL_WAKE_UP    4

// Interrupt status bits
`define IRQ_SHUTDOWN    0
`define IRQ_STANDBY     1
`define IRQ_LOW_SUPPLY  2
`define IRQ_LOW_RSSI    3
`define IRQ_WIDTH       4

// Reset values
`define SUPPLY_THR_RST  8'h00
`define RSSI_THR_RST    8'h00

// Timing: minimum host low pulses and wake settle in microseconds, fast clock in MHz, slow clock divider
`define SHUTDOWN_MIN_US 10000
`define STANDBY_MIN_US  160000
`define WAKE_SETTLE_US  5000
`define FAST_CLK_MHZ    100
`define SLOW_DIV        3125

`endif

// >>> logic/host_pins_pkg.sv
package host_pins_pkg;

  typedef enum logic [2:0] {
    ST_POWER_ON,
    ST_STANDBY,
    ST_CONNECTED,
    ST_SESSION,
    ST_SHUTDOWN
  } link_state_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } bus_req_t;

  typedef struct packed {
    logic status_first;
    logic status_second;
  } status_code_t;

endpackage

// >>> logic/low_pulse_timer.sv
`timescale 1ns/1ps
// Times a low level on a host input; fires once when it reaches the minimum.
module low_pulse_timer
  import host_pins_pkg::*;
#(
  parameter int CNT_W = 25
)(
  input  wire logic             clk_sys,  // System clock
  input  wire logic             rst_b,    // Async reset, active low
  input  wire logic             tick,     // Counting enable
  input  wire logic             pin_b,    // Host input, active low
  input  wire logic [CNT_W-1:0] min_cnt,  // Ticks needed
  output logic                  valid     // One-cycle pulse at the minimum
);

  logic [CNT_W-1:0] cnt_r;
  logic             done_r;

  // A release before the minimum clears the count, so short pulses do nothing
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cnt_r  <= '0;
      done_r <= 1'b0;
    end
    else if (pin_b)
    begin
      cnt_r  <= '0;
      done_r <= 1'b0;
    end
    else if (tick && !done_r)
    begin
      // Reaching rather than equality: the minimum shrinks on a clock switch
      if (cnt_r >= min_cnt - CNT_W'(1))
        done_r <= 1'b1;
      cnt_r <= cnt_r + CNT_W'(1);
    end
  end

  assign valid = tick && !pin_b && !done_r && (cnt_r >= min_cnt - CNT_W'(1));

endmodule // low_pulse_timer

// >>> logic/host_pins.sv
`timescale 1ns/1ps
`include "host_pins_defines.svh"

// Functional notes
// RULE1: Low-supply output goes low while supply measure is below software threshold.
// RULE2: Status pair: HH power on, HL standby, LL connected, LH session.
// RULE3: Link-quality output goes low while signal strength is below threshold.
// RULE4: Host holds forced-shutdown input low at least 10 ms.
// RULE5: Valid forced shutdown while connected drops link, enters shutdown.
// RULE6: Host holds pairing-key input low at least 160 ms.
// RULE7: Valid pairing-key request while connected drops link, returns to standby.
// RULE8: Fast clock normally; low-power bit set to 1 selects slow clock.
// RULE9: In low-power mode without wake request the UART is disabled.
// RULE10: Host asserts wake request and waits 5 ms before sending.
// RULE11: Wake request low forces fast clock and UART on.
// RULE12: Radio-activity output asserts while radio transmits or receives.
// RULE13: Host low pulses are timed; too-short pulses change nothing.
module host_pins
  import host_pins_pkg::*;
#(
  parameter int  CNT_W       = 25,
  parameter int  SHUTDOWN_US = `SHUTDOWN_MIN_US,
  parameter int  STANDBY_US  = `STANDBY_MIN_US,
  parameter int  SLOW_DIV    = `SLOW_DIV
)(
  input  wire logic        clk_sys,            // 100 MHz system clock
  input  wire logic        rst_b,              // Async reset, active low
  input  wire logic [7:0]  addr,               // Register byte address
  input  wire logic [31:0] wdata,              // Write data
  input  wire logic        wr,                 // Write strobe
  input  wire logic        rd,                 // Read strobe
  output logic      [31:0] rdata,              // Read data, cycle after rd
  output logic             irq,                // Level interrupt
  input  wire logic [7:0]  supply_level,       // Measured supply code
  input  wire logic [7:0]  rssi_level,         // Measured signal strength code
  input  wire logic        radio_busy,         // Radio transmit or receive active
  input  wire logic        shutdown_req_b,     // Forced shutdown input, active low
  input  wire logic        pairing_key_b,      // Pairing key input, active low
  input  wire logic        wake_req_b,         // Wake request input, active low
  output logic             low_supply_b,       // Low-supply warning, active low
  output logic             status_first,       // Status code first pin
  output logic             status_second,      // Status code second pin
  output logic             link_quality_warning, // Low when signal weak
  output logic             radio_activity_flag,  // High while radio active
  output logic             uart_enable,        // UART operational
  output logic             slow_clk_sel,       // Running on slow clock
  output logic             link_drop           // One-cycle request to drop link
);

  // ==========================================================
  // Tick generation
  // ==========================================================
  // Timers count microseconds on the fast clock; on the slow clock
  // the tick is derived from the slow rate so timing holds in both.
  localparam int US_DIV   = `FAST_CLK_MHZ;
  localparam int SLOW_US  = SLOW_DIV / US_DIV;

  logic [15:0]       div_r;
  logic              us_tick;
  logic [CNT_W-1:0]  shut_min;
  logic [CNT_W-1:0]  stby_min;
  logic              shut_valid;
  logic              stby_valid;
  logic              shut_tick;

  bus_req_t          req;
  link_state_t       state_r;
  logic [`IRQ_WIDTH-1:0] irq_stat_r;
  logic [`IRQ_WIDTH-1:0] irq_mask_r;
  logic [`IRQ_WIDTH-1:0] irq_set;
  logic [7:0]        supply_thr_r;
  logic [7:0]        rssi_thr_r;
  logic              low_power_r;
  logic              conn_req_r;
  logic              sess_req_r;
  logic              wake_up_r;
  logic              low_supply_r;
  logic              low_rssi_r;
  logic              radio_r;
  logic              fast_run;
  logic [1:0]        last_event_r;
  status_code_t      code_nxt;
  status_code_t      code_r;
  logic [31:0]       rdata_nxt;

  assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

  function automatic logic [CNT_W-1:0] us_to_ticks(input int us, input logic slow);
    int t;
    t = slow ? ((us + SLOW_US - 1) / SLOW_US) : us;
    if (t < 1)
      t = 1;
    return CNT_W'(t);
  endfunction

  // Wake request overrides low-power mode
  assign fast_run = !low_power_r || !wake_req_b;            // [RULE8] [RULE11]

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      div_r <= '0;
    else if (us_tick)
      div_r <= '0;
    else
      div_r <= div_r + 16'h0001;
  end

  // Compare by reaching, not equality: leaving low power can find the
  // divider above the fast limit, which would otherwise stall until wrap
  assign us_tick = fast_run ? (div_r >= 16'(US_DIV - 1))
                            : (div_r >= 16'(SLOW_DIV - 1));  // [RULE8]

  assign shut_min = us_to_ticks(SHUTDOWN_US, !fast_run);    // [RULE13]
  assign stby_min = us_to_ticks(STANDBY_US, !fast_run);     // [RULE13]
  assign shut_tick = us_tick;

  // ==========================================================
  // Host input timers
  // ==========================================================
  low_pulse_timer #(.CNT_W(CNT_W)) u_shut (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .tick    (shut_tick),
    .pin_b   (shutdown_req_b),
    .min_cnt (shut_min),
    .valid   (shut_valid)                                   // [RULE4] [RULE13]
  );

  low_pulse_timer #(.CNT_W(CNT_W)) u_stby (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .tick    (us_tick),
    .pin_b   (pairing_key_b),
    .min_cnt (stby_min),
    .valid   (stby_valid)                                   // [RULE6] [RULE13]
  );

  // ==========================================================
  // Link state
  // ==========================================================
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      state_r <= ST_POWER_ON;
    else
    begin
      case (state_r)
        ST_POWER_ON:
          state_r <= ST_STANDBY;
        ST_STANDBY:
          if (conn_req_r)
            state_r <= ST_CONNECTED;
        ST_CONNECTED, ST_SESSION:
          if (shut_valid)
            state_r <= ST_SHUTDOWN;                         // [RULE5]
          else if (stby_valid)
            state_r <= ST_STANDBY;                          // [RULE7]
          else if (!conn_req_r)
            state_r <= ST_STANDBY;
          else if (sess_req_r)
            state_r <= ST_SESSION;
          else
            state_r <= ST_CONNECTED;
        ST_SHUTDOWN:
          if (wake_up_r)
            state_r <= ST_POWER_ON;
        default:
          state_r <= ST_POWER_ON;
      endcase
    end
  end

  // Drop request fires only when a peer is really connected
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      link_drop <= 1'b0;
    else
      link_drop <= (state_r == ST_CONNECTED || state_r == ST_SESSION)
                   && (shut_valid || stby_valid);           // [RULE5] [RULE7]
  end

  always_comb
  begin
    case (state_r)
      ST_STANDBY:   code_nxt = '{status_first: 1'b1, status_second: 1'b0};
      ST_CONNECTED: code_nxt = '{status_first: 1'b0, status_second: 1'b0};
      ST_SESSION:   code_nxt = '{status_first: 1'b0, status_second: 1'b1};
      default:      code_nxt = '{status_first: 1'b1, status_second: 1'b1};
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      code_r <= '{status_first: 1'b1, status_second: 1'b1};
    else
      code_r <= code_nxt;                                   // [RULE2]
  end

  assign status_first  = code_r.status_first;
  assign status_second = code_r.status_second;

  // ==========================================================
  // Indications
  // ==========================================================
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      low_supply_r <= 1'b0;
      low_rssi_r   <= 1'b0;
      radio_r      <= 1'b0;
    end
    else
    begin
      low_supply_r <= supply_level < supply_thr_r;          // [RULE1]
      low_rssi_r   <= rssi_level < rssi_thr_r;              // [RULE3]
      radio_r      <= radio_busy;                           // [RULE12]
    end
  end

  assign low_supply_b         = !low_supply_r;
  assign link_quality_warning = !low_rssi_r;
  assign radio_activity_flag  = radio_r;

  // UART stays off in low power unless woken
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      uart_enable  <= 1'b1;
      slow_clk_sel <= 1'b0;
    end
    else
    begin
      uart_enable  <= fast_run;                             // [RULE9] [RULE11]
      slow_clk_sel <= !fast_run;                            // [RULE8]
    end
  end

  // ==========================================================
  // Interrupts
  // ==========================================================
  always_comb
  begin
    irq_set = '0;
    irq_set[`IRQ_SHUTDOWN]   = shut_valid;
    irq_set[`IRQ_STANDBY]    = stby_valid;
    irq_set[`IRQ_LOW_SUPPLY] = (supply_level < supply_thr_r) && !low_supply_r;
    irq_set[`IRQ_LOW_RSSI]   = (rssi_level < rssi_thr_r) && !low_rssi_r;
  end

  // Set wins over a write-one clear in the same cycle
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      irq_stat_r <= '0;
    else if (req.wr && req.addr == `REG_IRQ_STAT)
      irq_stat_r <= (irq_stat_r & ~req.wdata[`IRQ_WIDTH-1:0]) | irq_set;
    else
      irq_stat_r <= irq_stat_r | irq_set;
  end

  assign irq = |(irq_stat_r & irq_mask_r);

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      last_event_r <= 2'h0;
    else if (shut_valid)
      last_event_r <= 2'h1;
    else if (stby_valid)
      last_event_r <= 2'h2;
  end

  // ==========================================================
  // Register writes
  // ==========================================================
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      low_power_r  <= 1'b0;
      conn_req_r   <= 1'b0;
      sess_req_r   <= 1'b0;
      wake_up_r    <= 1'b0;
      supply_thr_r <= `SUPPLY_THR_RST;
      rssi_thr_r   <= `RSSI_THR_RST;
      irq_mask_r   <= '0;
    end
    else
    begin
      wake_up_r <= 1'b0;
      // A forced drop also withdraws the connection request
      if (shut_valid || stby_valid)
      begin
        conn_req_r <= 1'b0;
        sess_req_r <= 1'b0;
      end
      if (req.wr)
      begin
        if (req.addr == `REG_CTRL)
        begin
          low_power_r <= req.wdata[`CTRL_LOW_POWER];        // [RULE8]
          conn_req_r  <= req.wdata[`CTRL_CONNECT];
          sess_req_r  <= req.wdata[`CTRL_SESSION];
          wake_up_r   <= req.wdata[`CTRL_WAKE_UP];
        end
        else if (req.addr == `REG_SUPPLY_THR)
          supply_thr_r <= req.wdata[7:0];                   // [RULE1]
        else if (req.addr == `REG_RSSI_THR)
          rssi_thr_r <= req.wdata[7:0];                     // [RULE3]
        else if (req.addr == `REG_IRQ_MASK)
          irq_mask_r <= req.wdata[`IRQ_WIDTH-1:0];
      end
    end
  end

  // ==========================================================
  // Register reads
  // ==========================================================
  always_comb
  begin
    rdata_nxt = 32'h0000_0000;
    if (req.addr == `REG_CTRL)
      rdata_nxt = {27'h0, 1'b0, radio_r, sess_req_r, conn_req_r, low_power_r};
    else if (req.addr == `REG_STATE)
      rdata_nxt = {25'h0, fast_run, code_r.status_first, code_r.status_second,
                   1'b0, state_r};
    else if (req.addr == `REG_SUPPLY_THR)
      rdata_nxt = {24'h0, supply_thr_r};
    else if (req.addr == `REG_RSSI_THR)
      rdata_nxt = {24'h0, rssi_thr_r};
    else if (req.addr == `REG_MEAS)
      rdata_nxt = {14'h0, low_rssi_r, low_supply_r, rssi_level, supply_level};
    else if (req.addr == `REG_IRQ_STAT)
      rdata_nxt = {28'h0, irq_stat_r};
    else if (req.addr == `REG_IRQ_MASK)
      rdata_nxt = {28'h0, irq_mask_r};
    else if (req.addr == `REG_EVENT)
      rdata_nxt = {30'h0, last_event_r};
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      rdata <= 32'h0000_0000;
    else if (req.rd)
      rdata <= rdata_nxt;
    else
      rdata <= 32'h0000_0000;
  end

endmodule // host_pins

// >>> test/host_pins_sva.sv
`timescale 1ns/1ps
// ==========================================
// Checks on the host indication and control pins
module host_pins_sva
  import host_pins_pkg::*;
#(
  parameter int SHUTDOWN_US = 10000,
  parameter int STANDBY_US  = 160000
)(
  input wire logic        clk_sys,              // Clock
  input wire logic        rst_b,                // Reset
  input wire logic [7:0]  addr,                 // Address
  input wire logic [31:0] wdata,                // Write data
  input wire logic        wr,                   // Write strobe
  input wire logic [7:0]  supply_level,         // Supply code
  input wire logic [7:0]  rssi_level,           // Strength code
  input wire logic        radio_busy,           // Radio active
  input wire logic        shutdown_req_b,       // Shutdown pin
  input wire logic        pairing_key_b,        // Pairing pin
  input wire logic        wake_req_b,           // Wake pin
  input wire logic        low_supply_b,         // Supply warning
  input wire logic        status_first,         // Status pin 1
  input wire logic        link_quality_warning, // Strength warning
  input wire logic        radio_activity_flag,  // Radio flag
  input wire logic        uart_enable,          // UART on
  input wire logic        slow_clk_sel,         // Slow clock
  input wire logic        link_drop             // Drop pulse
);
  // One tick of slack: the microsecond divider runs free of the pin
  localparam int SD_MIN = (SHUTDOWN_US - 1) * 100;
  localparam int PK_MIN = (STANDBY_US - 1) * 100;
  logic [7:0] sup_thr_r;
  logic [7:0] rssi_thr_r;
  logic       lp_r;
  int         sd_cnt_r;
  int         pk_cnt_r;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b) begin sup_thr_r <= 8'h00; rssi_thr_r <= 8'h00; end
    else if (wr && addr == 8'h08) sup_thr_r <= wdata[7:0];
    else if (wr && addr == 8'h0C) rssi_thr_r <= wdata[7:0];
  end

  // Mirror of the low-power control bit, so the clock choice is checked
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      lp_r <= 1'b0;
    else if (wr && addr == 8'h00)
      lp_r <= wdata[0];
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b) begin sd_cnt_r <= 0; pk_cnt_r <= 0; end
    else
    begin
      sd_cnt_r <= shutdown_req_b ? 0 : sd_cnt_r + 1;
      pk_cnt_r <= pairing_key_b ? 0 : pk_cnt_r + 1;
    end
  end

  // ==========================================
  // Properties
  property p_supply;
    low_supply_b == !($past(supply_level) < $past(sup_thr_r));
  endproperty
  a_supply: assert property (p_supply) else $error("supply warning wrong");
  property p_rssi;
    link_quality_warning == !($past(rssi_level) < $past(rssi_thr_r));
  endproperty
  a_rssi: assert property (p_rssi) else $error("strength warning wrong");
  property p_drop_conn;
    link_drop |-> !status_first ##1 status_first;
  endproperty
  a_drop_conn: assert property (p_drop_conn) else $error("drop not from link");
  property p_drop_min;
    link_drop |-> (sd_cnt_r >= SD_MIN) || (pk_cnt_r >= PK_MIN);
  endproperty
  a_drop_min: assert property (p_drop_min) else $error("drop on short pulse");
  property p_drop_once;
    link_drop |=> !link_drop [*2];
  endproperty
  a_drop_once: assert property (p_drop_once) else $error("drop too long");
  property p_clk_sel;
    (uart_enable != slow_clk_sel) && (slow_clk_sel == ($past(lp_r) && $past(wake_req_b)));
  endproperty
  a_clk_sel: assert property (p_clk_sel) else $error("clock select wrong");
  property p_wake;
    !wake_req_b |=> uart_enable && !slow_clk_sel;
  endproperty
  a_wake: assert property (p_wake) else $error("wake ignored");
  property p_uart_off;
    $fell(uart_enable) |-> $past(wake_req_b);
  endproperty
  a_uart_off: assert property (p_uart_off) else $error("UART off while woken");
  property p_radio;
    radio_activity_flag == $past(radio_busy);
  endproperty
  a_radio: assert property (p_radio) else $error("radio flag wrong");

  c_drop: cover property (link_drop);
  c_supply: cover property (!low_supply_b);
  c_wake: cover property (!wake_req_b ##1 uart_enable);
endmodule // host_pins_sva

bind host_pins host_pins_sva #(.SHUTDOWN_US(SHUTDOWN_US), .STANDBY_US(STANDBY_US)) chk_u (
  .clk_sys, .rst_b, .addr, .wdata, .wr, .supply_level, .rssi_level, .radio_busy,
  .shutdown_req_b, .pairing_key_b, .wake_req_b, .low_supply_b, .status_first,
  .link_quality_warning, .radio_activity_flag, .uart_enable, .slow_clk_sel, .link_drop
);

// >>> test/host_mcu_model.sv
`timescale 1ns/1ps
// ==========================================
// Host side: drives the active-low control pins
module host_mcu_model #(
  parameter int SETTLE_CYC = 500000
)(
  input  wire logic clk_sys,        // Clock
  output logic      shutdown_req_b, // Shutdown pin
  output logic      pairing_key_b,  // Pairing pin
  output logic      wake_req_b      // Wake pin
);
  // Pins idle high, as the device pulls them up
  initial
  begin
    shutdown_req_b = 1'b1;
    pairing_key_b  = 1'b1;
    wake_req_b     = 1'b1;
  end

  // Held low without a glitch for the given cycles
  task automatic hold_low(input int pin, input int cyc);
    @(posedge clk_sys);
    if (pin == 0) shutdown_req_b <= 1'b0;
    else pairing_key_b <= 1'b0;
    repeat (cyc) @(posedge clk_sys);
    shutdown_req_b <= 1'b1;
    pairing_key_b  <= 1'b1;
  endtask

  // No traffic until the settle time has passed
  task automatic wake(input logic on);
    @(posedge clk_sys);
    wake_req_b <= !on;
    if (on) repeat (SETTLE_CYC) @(posedge clk_sys);
  endtask
endmodule // host_mcu_model

// >>> test/host_pins_tb_top.sv
`timescale 1ns/1ps
module host_pins_tb_top
  import host_pins_pkg::*;
;
  logic clk_sys, rst_b, wr, rd, radio_busy, irq, low_supply_b, status_first, status_second;
  logic link_quality_warning, radio_activity_flag, uart_enable, slow_clk_sel, link_drop;
  logic shutdown_req_b, pairing_key_b, wake_req_b;
  logic [7:0]  addr, supply_level, rssi_level;
  logic [31:0] wdata, rdata;
  int mismatches, compares, drops;

  host_pins #(.SHUTDOWN_US(3), .STANDBY_US(5)) dut_u (
    .clk_sys(clk_sys), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .irq(irq), .supply_level(supply_level), .rssi_level(rssi_level),
    .radio_busy(radio_busy), .shutdown_req_b(shutdown_req_b),
    .pairing_key_b(pairing_key_b), .wake_req_b(wake_req_b), .low_supply_b(low_supply_b),
    .status_first(status_first), .status_second(status_second),
    .link_quality_warning(link_quality_warning), .radio_activity_flag(radio_activity_flag),
    .uart_enable(uart_enable), .slow_clk_sel(slow_clk_sel), .link_drop(link_drop));
  host_mcu_model #(.SETTLE_CYC(50)) host_u (.clk_sys(clk_sys),
    .shutdown_req_b(shutdown_req_b), .pairing_key_b(pairing_key_b), .wake_req_b(wake_req_b));

  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) if (link_drop === 1'b1) drops++;

  // ==========================================
  // Access and compare tasks
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_sys);
    addr <= a; rd <= 1'b1;
    @(posedge clk_sys);
    rd <= 1'b0;
    #1 check("rdata", rdata, exp);
  endtask
  task automatic settle();
    repeat (3) @(posedge clk_sys);
    #1;
  endtask
  task automatic stop_test();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  initial
  begin
    #500000;
    mismatches++;
    stop_test();
  end

  // ==========================================
  // Main sequence
  initial
  begin
    rst_b = 1'b0; addr = 8'h00; wdata = 32'h0; wr = 1'b0; rd = 1'b0;
    supply_level = 8'h80; rssi_level = 8'h80; radio_busy = 1'b0;
    repeat (4) @(posedge clk_sys);
    check("status", {status_first, status_second}, 32'h3);
    rst_b <= 1'b1;
    settle();
    check("status", {status_first, status_second}, 32'h2);
    rd_reg(8'h04, 32'h61);
    rd_reg(8'h20, 32'h0);
    wr_reg(8'h18, 32'hF);
    for (int i = 0; i < 2; i++)
    begin
      wr_reg(8'h08 + 8'(4 * i), 32'h40);
      if (i == 0) supply_level <= 8'h3F; else rssi_level <= 8'h3F;
      settle();
      check("warn", i ? link_quality_warning : low_supply_b, 32'h0);
      check("irq", irq, 32'h1);
      rd_reg(8'h14, 32'h4 << i);
      wr_reg(8'h14, 32'h4 << i);
      if (i == 0) supply_level <= 8'h40; else rssi_level <= 8'h40;
      settle();
      check("warn", i ? link_quality_warning : low_supply_b, 32'h1);
      check("irq", irq, 32'h0);
    end
    radio_busy <= 1'b1;
    settle();
    check("radio", radio_activity_flag, 32'h1);
    rd_reg(8'h00, 32'h8);
    radio_busy <= 1'b0;
    wr_reg(8'h00, 32'h6);
    settle();
    check("status", {status_first, status_second}, 32'h1);
    wr_reg(8'h00, 32'h2);
    settle();
    check("status", {status_first, status_second}, 32'h0);
    host_u.hold_low(0, 150);
    host_u.hold_low(1, 300);
    settle();
    rd_reg(8'h04, 32'h42);
    check("drops", drops, 32'h0);
    host_u.hold_low(0, 400);
    settle();
    check("drops", drops, 32'h1);
    rd_reg(8'h04, 32'h74);
    rd_reg(8'h1C, 32'h1);
    rd_reg(8'h14, 32'h1);
    wr_reg(8'h14, 32'h1);
    wr_reg(8'h00, 32'h10);
    wr_reg(8'h00, 32'h2);
    settle();
    host_u.hold_low(1, 600);
    settle();
    check("drops", drops, 32'h2);
    rd_reg(8'h04, 32'h61);
    rd_reg(8'h1C, 32'h2);
    wr_reg(8'h00, 32'h1);
    settle();
    check("uart", {uart_enable, slow_clk_sel}, 32'h1);
    rd_reg(8'h04, 32'h21);
    host_u.wake(1'b1);
    check("uart", {uart_enable, slow_clk_sel}, 32'h2);
    host_u.wake(1'b0);
    settle();
    check("uart", {uart_enable, slow_clk_sel}, 32'h1);
    stop_test();
  end
endmodule // host_pins_tb_top
